// file: verilog/src_conditioner.sv
// Speed reference conditioner: offset removal, soft start, delay filter, APB registers
// Functional notes
// - Linear ramp with separate accel/decel millisecond times
// - Two-bit selector picks soft-start shape
// - Both times zero bypasses soft-start shaping
// - First-order delay filter, zero means none
// - Subtract stored zero offset from reference
// - Auto adjustment stores measured offset
// - Auto adjustment only with servo off
// - Mode key held one second starts measurement
// - Manual mode writes offset directly
// - Manual mode reads back stored offset
// - Enter held one second toggles offset display
// - Increment/decrement keys step offset by one
//
// Chosen here: the APB interface to the registers and the register addresses.
`default_nettype none
module src_conditioner
  import src_pkg::*;
#(
  parameter int CYC_PER_MS = CTRL_CYC,
  parameter int HOLD_CYC   = KEY_HOLD_CYC
)(
  input  wire logic               CLK,
  input  wire logic               RST,
  input  wire logic               CE,
  input  wire logic               PSEL,
  input  wire logic               PENABLE,
  input  wire logic               PWRITE,
  input  wire logic [7:0]         PADDR,
  input  wire logic [31:0]        PWDATA,
  output logic      [31:0]        PRDATA,
  output logic                    PREADY,
  output logic                    PSLVERR,
  input  wire logic signed [15:0] REF_IN,
  input  wire logic               SERVO_ON,
  input  wire logic               MODE_KEY,
  input  wire logic               ENTER_KEY,
  input  wire logic               INCREMENT_KEY,
  input  wire logic               DECREMENT_KEY,
  output logic signed [15:0]      SPEED_REF_OUT,
  output logic                    OFFSET_SHOWN
);
  logic [1:0]         soft_start_form_sel;
  logic               offset_auto_adjust_mode;
  logic               offset_manual_adjust_mode;
  logic [13:0]        accel_ramp_time;
  logic [13:0]        decel_ramp_time;
  logic [13:0]        ref_filter_time_const;
  logic [13:0]        scurve_rise_time;
  logic signed [15:0] offset;
  logic signed [15:0] src;
  logic signed [15:0] ramp;
  logic signed [15:0] stage_a;
  logic signed [15:0] stage_b;
  logic [31:0]        ramp_acc;
  logic [31:0]        tick_cnt;
  logic               tick;
  logic [31:0]        hold_cnt;
  src_key_e           key_st;
  logic               inc_q;
  logic               dec_q;
  logic               auto_fire;
  logic               man_fire;
  logic               wr_en;
  logic               access;
  logic               bypass;
  logic               ramp_up;
  logic [13:0]        ramp_time;
  logic [31:0]        ramp_lim;
  logic               ramp_active;
  logic [13:0]        filt_sel;
  logic signed [16:0] next_src;
  logic signed [15:0] next_stage_a;

  // Smallest shift whose power of two reaches the time constant in ms
  function automatic logic [3:0] tc_shift(input logic [13:0] t);
    logic [3:0] k;
    k = 4'h0;
    for (int i = 13; i >= 0; i--)
    begin
      if ((15'(1) << i) < {1'b0, t} && k == 4'h0)
        k = 4'(i + 1);
    end
    return k;
  endfunction : tc_shift

  // One first-order step toward the input
  function automatic logic signed [15:0] lag(input logic signed [15:0] y,
                                             input logic signed [15:0] x,
                                             input logic [13:0] t);
    logic signed [16:0] d;
    d = 17'(x) - 17'(y);
    return 16'(17'(y) + (d >>> tc_shift(t)));
  endfunction : lag

  // Clamp a time setting to its legal range
  function automatic logic [13:0] clamp_t(input logic [31:0] v);
    return (v > 32'(TIME_MAX)) ? TIME_MAX : v[13:0];
  endfunction : clamp_t

  assign access      = PSEL && PENABLE && !PREADY;
  assign wr_en       = CE && access && PWRITE;
  assign bypass      = (accel_ramp_time == 14'h0000) && (decel_ramp_time == 14'h0000);
  assign ramp_up     = src > ramp;
  assign ramp_time   = ((ramp >= 0) == ramp_up) ? accel_ramp_time : decel_ramp_time;
  assign ramp_lim    = 32'(ramp_time) * 32'(CYC_PER_MS);
  assign ramp_active = !bypass && (ramp_time != 14'h0000) && (src != ramp);
  assign filt_sel    = ((stage_a >= 0) == (ramp > stage_a)) ? accel_ramp_time : decel_ramp_time;
  assign tick        = CE && (tick_cnt == 32'(CYC_PER_MS - 1));
  assign next_src    = 17'(REF_IN) - 17'(offset);

  // Control cycle timer, one tick per millisecond
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
      tick_cnt <= 32'h0000_0000;
    else if (CE)
      tick_cnt <= tick ? 32'h0000_0000 : tick_cnt + 32'h0000_0001;
  end

  // APB handshake: ready in the second access cycle, error on unmapped address
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA  <= 32'h0000_0000;
    end
    else if (CE)
    begin
      PREADY  <= access;
      PSLVERR <= 1'b0;
      PRDATA  <= 32'h0000_0000;
      if (access)
      begin
        unique case (PADDR)
          ADDR_CTRL:   PRDATA <= 32'({offset_manual_adjust_mode, offset_auto_adjust_mode,
                                      soft_start_form_sel});
          ADDR_ACCEL:  PRDATA <= 32'(accel_ramp_time);
          ADDR_DECEL:  PRDATA <= 32'(decel_ramp_time);
          ADDR_FILT:   PRDATA <= 32'(ref_filter_time_const);
          ADDR_SCURVE: PRDATA <= 32'(scurve_rise_time);
          ADDR_OFFSET: PRDATA <= 32'(unsigned'(offset));
          ADDR_STATUS: PRDATA <= {14'h0000, OFFSET_SHOWN, SERVO_ON, SPEED_REF_OUT};
          default:     PSLVERR <= 1'b1;
        endcase
      end
    end
  end

  // Configuration registers
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      soft_start_form_sel       <= FORM_SLOPE;
      offset_auto_adjust_mode   <= 1'b0;
      offset_manual_adjust_mode <= 1'b0;
      accel_ramp_time           <= ACCEL_RESET;
      decel_ramp_time           <= DECEL_RESET;
      ref_filter_time_const     <= FILT_RESET;
      scurve_rise_time          <= SCURVE_RESET;
    end
    else if (wr_en)
    begin
      unique case (PADDR)
        ADDR_CTRL:
        begin
          soft_start_form_sel       <= PWDATA[CTRL_FORM_LSB +: 2];
          offset_auto_adjust_mode   <= PWDATA[CTRL_AUTO_BIT] && !PWDATA[CTRL_MAN_BIT];
          offset_manual_adjust_mode <= PWDATA[CTRL_MAN_BIT];
        end
        ADDR_ACCEL:  accel_ramp_time       <= clamp_t(PWDATA);
        ADDR_DECEL:  decel_ramp_time       <= clamp_t(PWDATA);
        ADDR_FILT:   ref_filter_time_const <= clamp_t(PWDATA);
        ADDR_SCURVE: scurve_rise_time      <= clamp_t(PWDATA);
        default:     ;
      endcase
    end
  end

  // Key hold tracker: fires once per hold of one second
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      key_st   <= KEY_IDLE;
      hold_cnt <= 32'h0000_0000;
    end
    else if (CE)
    begin
      unique case (key_st)
        KEY_IDLE:
        begin
          hold_cnt <= 32'h0000_0000;
          if ((offset_auto_adjust_mode && MODE_KEY) ||
              (offset_manual_adjust_mode && ENTER_KEY && SERVO_ON))
            key_st <= KEY_HOLD;
        end
        KEY_HOLD:
        begin
          hold_cnt <= hold_cnt + 32'h0000_0001;
          if (!(MODE_KEY || ENTER_KEY))
            key_st <= KEY_IDLE;
          else if (hold_cnt == 32'(HOLD_CYC - 2))
            key_st <= KEY_FIRED;
        end
        KEY_FIRED:
          if (!(MODE_KEY || ENTER_KEY))
            key_st <= KEY_IDLE;
        default:
          key_st <= KEY_IDLE;
      endcase
    end
  end

  assign auto_fire = CE && key_st == KEY_HOLD && hold_cnt == 32'(HOLD_CYC - 2) &&
                     offset_auto_adjust_mode && MODE_KEY && !SERVO_ON;
  assign man_fire  = CE && key_st == KEY_HOLD && hold_cnt == 32'(HOLD_CYC - 2) &&
                     offset_manual_adjust_mode && ENTER_KEY && SERVO_ON;

  // Offset store: measured, written by software, or stepped by keys
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      offset       <= OFFSET_RESET;
      OFFSET_SHOWN <= 1'b0;
      inc_q        <= 1'b0;
      dec_q        <= 1'b0;
    end
    else if (CE)
    begin
      inc_q <= INCREMENT_KEY;
      dec_q <= DECREMENT_KEY;
      if (!offset_manual_adjust_mode || !SERVO_ON)
        OFFSET_SHOWN <= 1'b0;
      else if (man_fire)
        OFFSET_SHOWN <= !OFFSET_SHOWN;
      if (auto_fire)
        offset <= REF_IN;
      else if (wr_en && PADDR == ADDR_OFFSET && offset_manual_adjust_mode)
        offset <= PWDATA[15:0];
      else if (OFFSET_SHOWN && INCREMENT_KEY && !inc_q && offset != REF_POS_MAX)
        offset <= offset + 16'sh0001;
      else if (OFFSET_SHOWN && DECREMENT_KEY && !dec_q && offset != REF_NEG_MAX)
        offset <= offset - 16'sh0001;
    end
  end

  // Offset-corrected sample taken each control cycle
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
      src <= 16'sh0000;
    else if (tick)
    begin
      if (next_src > 17'(REF_POS_MAX))
        src <= REF_POS_MAX;
      else if (next_src < 17'(REF_NEG_MAX))
        src <= REF_NEG_MAX;
      else
        src <= 16'(next_src);
    end
  end

  // Linear ramp: one step per full-scale share of the time setting
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      ramp     <= 16'sh0000;
      ramp_acc <= 32'h0000_0000;
    end
    else if (CE)
    begin
      if (bypass || ramp_time == 14'h0000 ||
          soft_start_form_sel == FORM_FIRST || soft_start_form_sel == FORM_SECOND)
      begin
        ramp     <= src;
        ramp_acc <= 32'h0000_0000;
      end
      else if (ramp_active)
      begin
        if (ramp_acc + FULL_SCALE >= ramp_lim)
        begin
          ramp_acc <= ramp_acc + FULL_SCALE - ramp_lim;
          ramp     <= ramp_up ? ramp + 16'sh0001 : ramp - 16'sh0001;
        end
        else
          ramp_acc <= ramp_acc + FULL_SCALE;
      end
      else
        ramp_acc <= 32'h0000_0000;
    end
  end

  // Shape selection after the ramp
  always_comb
  begin
    next_stage_a = ramp;
    if (!bypass)
    begin
      unique case (soft_start_form_sel)
        FORM_SLOPE:  next_stage_a = ramp;
        FORM_SCURVE: next_stage_a = lag(stage_a, ramp, scurve_rise_time);
        FORM_FIRST:  next_stage_a = lag(stage_a, ramp, filt_sel);
        FORM_SECOND: next_stage_a = lag(stage_a, ramp, filt_sel);
      endcase
    end
  end

  // Shaping stages and delay filter, once per control cycle
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      stage_a       <= 16'sh0000;
      stage_b       <= 16'sh0000;
      SPEED_REF_OUT <= 16'sh0000;
    end
    else if (tick)
    begin
      stage_a <= next_stage_a;
      if (!bypass && soft_start_form_sel == FORM_SECOND)
        stage_b <= lag(stage_b, stage_a, filt_sel);
      else
        stage_b <= next_stage_a;
      SPEED_REF_OUT <= lag(SPEED_REF_OUT, stage_b, ref_filter_time_const);
    end
  end

  // Checks
  a_ramp_rate: assert property (@(posedge CLK) disable iff (RST)
    ramp_active && CE && soft_start_form_sel == FORM_SLOPE |=>
      (ramp - $past(ramp) <= 16'sh0001) && ($past(ramp) - ramp <= 16'sh0001))
    else $error("ramp moved more than one step");
  a_slope_pass: assert property (@(posedge CLK) disable iff (RST)
    tick && soft_start_form_sel == FORM_SLOPE |=> stage_a == $past(ramp))
    else $error("slope form altered ramp");
  a_bypass_pass: assert property (@(posedge CLK) disable iff (RST)
    CE && bypass |=> ramp == $past(src))
    else $error("bypass did not pass reference");
  a_filter_off: assert property (@(posedge CLK) disable iff (RST)
    tick && ref_filter_time_const == 14'h0000 |=> SPEED_REF_OUT == $past(stage_b))
    else $error("zero filter time still filtered");
  a_offset_sub: assert property (@(posedge CLK) disable iff (RST)
    tick && REF_IN == offset |=> src == 16'sh0000)
    else $error("zero reference not nulled");
  a_auto_store: assert property (@(posedge CLK) disable iff (RST)
    auto_fire |=> offset == $past(REF_IN))
    else $error("auto offset not stored");
  a_auto_servo: assert property (@(posedge CLK) disable iff (RST)
    CE && SERVO_ON |-> !auto_fire)
    else $error("auto adjust with servo on");
  a_show_toggle: assert property (@(posedge CLK) disable iff (RST)
    man_fire |=> OFFSET_SHOWN != $past(OFFSET_SHOWN))
    else $error("display did not toggle");
  a_inc_step: assert property (@(posedge CLK) disable iff (RST)
    CE && OFFSET_SHOWN && INCREMENT_KEY && !inc_q && !auto_fire && !wr_en &&
      offset != REF_POS_MAX |=> offset == $past(offset) + 16'sh0001)
    else $error("increment did not step offset");
  c_auto: cover property (@(posedge CLK) disable iff (RST) auto_fire);
  c_show: cover property (@(posedge CLK) disable iff (RST) man_fire ##1 OFFSET_SHOWN);
  c_ramp: cover property (@(posedge CLK) disable iff (RST) ramp_active [*4]);
endmodule : src_conditioner
`default_nettype wire

// file: verilog/src_pkg.sv
// Constants shared by the speed reference conditioner
`default_nettype none
package src_pkg;
  // Clock and timing
  localparam int CLK_PERIOD_NS  = 50;
  localparam int CTRL_PERIOD_NS = 1000000;
  localparam int CTRL_CYC       = CTRL_PERIOD_NS / CLK_PERIOD_NS;
  localparam int KEY_HOLD_MS    = 1000;
  localparam int KEY_HOLD_CYC   = KEY_HOLD_MS * (1000000 / CLK_PERIOD_NS);
  // Register byte addresses
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_ACCEL  = 8'h04;
  localparam logic [7:0] ADDR_DECEL  = 8'h08;
  localparam logic [7:0] ADDR_FILT   = 8'h0C;
  localparam logic [7:0] ADDR_SCURVE = 8'h10;
  localparam logic [7:0] ADDR_OFFSET = 8'h14;
  localparam logic [7:0] ADDR_STATUS = 8'h18;
  // Control field positions
  localparam int CTRL_FORM_LSB = 0;
  localparam int CTRL_AUTO_BIT = 2;
  localparam int CTRL_MAN_BIT  = 3;
  // Time settings in ms, and reset values
  localparam logic [13:0] TIME_MAX       = 14'h2710;
  localparam logic [13:0] ACCEL_RESET    = 14'h0064;
  localparam logic [13:0] DECEL_RESET    = 14'h0064;
  localparam logic [13:0] FILT_RESET     = 14'h0000;
  localparam logic [13:0] SCURVE_RESET   = 14'h0000;
  localparam logic [15:0] OFFSET_RESET   = 16'h0000;
  // Reference full scale and saturation
  localparam logic [31:0] FULL_SCALE = 32'h0000_7FFF;
  localparam logic signed [15:0] REF_POS_MAX = 16'sh7FFF;
  localparam logic signed [15:0] REF_NEG_MAX = -16'sh7FFF;
  // Soft-start form encodings
  typedef enum logic [1:0] {
    FORM_SLOPE  = 2'h0,
    FORM_SCURVE = 2'h1,
    FORM_FIRST  = 2'h2,
    FORM_SECOND = 2'h3
  } src_form_e;
  // Key hold tracker, Gray coded
  typedef enum logic [1:0] {
    KEY_IDLE  = 2'b00,
    KEY_HOLD  = 2'b01,
    KEY_FIRED = 2'b11
  } src_key_e;
endpackage : src_pkg
`default_nettype wire

// file: bench/src_host_model.sv
// Host controller model driving the sampled analog speed reference
`default_nettype none
module src_host_model
(
  input  wire logic               clk,
  input  wire logic signed [15:0] nominal,
  input  wire logic signed [15:0] drift,
  output logic signed [15:0]      ref_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // Source adds its own small drift on top of the commanded level
  always_ff @(posedge clk)
  begin
    ref_out <= nominal + drift; // Nominal held at zero while offset is measured
  end
endmodule : src_host_model
`default_nettype wire

// file: bench/speed_reference_conditioner_bench.sv
// Self-checking bench for the speed reference conditioner
`default_nettype none
`define CHK(got, exp, msg) begin n_checks++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("unexpected at %0t: %s", $time, msg); end end
module speed_reference_conditioner_bench;
  import src_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int MS = 8;
  localparam int HOLD = 16;
  logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic servo_on = 1'b0, mode_key = 1'b0, enter_key = 1'b0, inc_key = 1'b0, dec_key = 1'b0;
  logic ce = 1'b1;
  logic        [7:0]  paddr = 8'h00;
  logic        [31:0] pwdata = 32'h0, prdata, q;
  logic               pready, pslverr, shown, err;
  logic signed [15:0] nominal = 16'sh0, drift = 16'sh0, ref_in, out;
  int n_mismatch = 0, n_checks = 0;
  // Free-running bench clock, 50 ns period
  always #25 clk = ~clk;
  src_host_model host_u (.clk(clk), .nominal(nominal), .drift(drift), .ref_out(ref_in));
  src_conditioner #(.CYC_PER_MS(MS), .HOLD_CYC(HOLD)) dut_u (
    .CLK(clk), .RST(rst), .CE(ce), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .REF_IN(ref_in), .SERVO_ON(servo_on), .MODE_KEY(mode_key), .ENTER_KEY(enter_key),
    .INCREMENT_KEY(inc_key), .DECREMENT_KEY(dec_key), .SPEED_REF_OUT(out),
    .OFFSET_SHOWN(shown));
  // One APB transfer: setup, then access until ready is seen at an edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    // This wait ends when ready is seen at an edge
    do
    begin
      @(posedge clk);
    end
    while (pready !== 1'b1);
    q   = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Holds one panel key for the given number of cycles
  task automatic hold_key(input int which, input int cyc);
    @(posedge clk);
    if (which == 0)
      mode_key <= 1'b1;
    else if (which == 1)
      enter_key <= 1'b1;
    else if (which == 2)
      inc_key <= 1'b1;
    else
      dec_key <= 1'b1;
    repeat (cyc) @(posedge clk);
    mode_key  <= 1'b0;
    enter_key <= 1'b0;
    inc_key   <= 1'b0;
    dec_key   <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : hold_key
  // Reset values, time clamp, unmapped access, form codes
  task automatic t_regs;
    apb(0, ADDR_ACCEL, 0);  `CHK(q[13:0], 14'h0064, "accel reset")
    apb(0, ADDR_DECEL, 0);  `CHK(q[13:0], 14'h0064, "decel reset")
    apb(0, ADDR_FILT, 0);   `CHK(q[13:0], 14'h0000, "filter reset")
    apb(0, ADDR_SCURVE, 0); `CHK(q[13:0], 14'h0000, "rise reset")
    apb(1, ADDR_SCURVE, 32'h0000_4E20);
    apb(0, ADDR_SCURVE, 0); `CHK(q[13:0], TIME_MAX, "rise clamp")
    apb(1, ADDR_SCURVE, 0);
    apb(0, 8'h1C, 0);       `CHK(err, 1'b1, "unmapped no error")
    for (int f = 0; f < 4; f++)
    begin
      apb(1, ADDR_CTRL, f);
      apb(0, ADDR_CTRL, 0); `CHK(q[1:0], f[1:0], "form readback")
    end
    apb(1, ADDR_CTRL, 0);
  endtask : t_regs
  // Default 100 ms accel time limits the slope to one step per clock
  task automatic t_ramp;
    nominal <= 16'sd500;
    repeat (3 * MS) @(posedge clk);
    `CHK(out < 16'sd500 && out > 16'sd0, 1'b1, "no slope on step")
    repeat (600) @(posedge clk);
    `CHK(out, 16'sd500, "ramp end value")
  endtask : t_ramp
  // Both times zero passes the step; offset then subtracted
  task automatic t_bypass;
    apb(1, ADDR_ACCEL, 0);
    apb(1, ADDR_DECEL, 0);
    nominal <= 16'sd1000;
    repeat (4 * MS) @(posedge clk);
    `CHK(out, 16'sd1000, "bypass value")
    apb(1, ADDR_CTRL, 32'h8);
    apb(1, ADDR_OFFSET, 32'h64);
    repeat (4 * MS) @(posedge clk);
    `CHK(out, 16'sd900, "offset not removed")
    apb(1, ADDR_CTRL, 0);
  endtask : t_bypass
  // Auto measurement refused with servo on, taken with servo off
  task automatic t_auto;
    apb(1, ADDR_CTRL, 32'h4);
    nominal <= 16'sd0;
    drift <= 16'sd37;
    servo_on <= 1'b1;
    hold_key(0, HOLD + 6);
    apb(0, ADDR_OFFSET, 0); `CHK(q[15:0], 16'h0064, "auto ran with servo on")
    servo_on <= 1'b0;
    hold_key(0, HOLD + 6);
    apb(0, ADDR_OFFSET, 0); `CHK(q[15:0], 16'h0025, "auto offset")
    repeat (4 * MS) @(posedge clk);
    `CHK(out, 16'sd0, "zero reference not zero")
  endtask : t_auto
  // Manual display toggle and single steps
  task automatic t_manual;
    apb(1, ADDR_CTRL, 32'h8);
    servo_on <= 1'b1;
    hold_key(1, HOLD + 6);
    `CHK(shown, 1'b1, "offset not shown")
    apb(0, ADDR_STATUS, 0); `CHK(q[17:16], 2'b11, "status flags")
    hold_key(2, 2);
    apb(0, ADDR_OFFSET, 0); `CHK(q[15:0], 16'h0026, "increment")
    hold_key(3, 2);
    hold_key(3, 2);
    apb(0, ADDR_OFFSET, 0); `CHK(q[15:0], 16'h0024, "decrement")
    hold_key(1, HOLD + 6);
    `CHK(shown, 1'b0, "display not left")
  endtask : t_manual
  // Clock enable low freezes the path; offset 36 against source 37 leaves 1
  task automatic t_freeze;
    ce <= 1'b0;
    nominal <= 16'sd200;
    repeat (4 * MS) @(posedge clk);
    `CHK(out, 16'sd1, "output moved while frozen")
    ce <= 1'b1;
    repeat (4 * MS) @(posedge clk);
    `CHK(out, 16'sd201, "did not resume after freeze")
  endtask : t_freeze
  // First-order form with 4 ms: quarter steps, settles within three LSB
  task automatic t_shape;
    apb(1, ADDR_CTRL, 32'h2);
    apb(1, ADDR_ACCEL, 32'h4);
    apb(1, ADDR_DECEL, 32'h4);
    nominal <= 16'sd1200;
    repeat (4 * MS) @(posedge clk);
    `CHK(out > 16'sd201 && out < 16'sd1201, 1'b1, "step not shaped")
    repeat (50 * MS) @(posedge clk);
    `CHK(out >= 16'sd1198 && out <= 16'sd1201, 1'b1, "filter not settled")
  endtask : t_shape
  // Prints counts and verdict, then ends the run
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : report_and_stop
  // Main sequence
  initial
  begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_ramp();
    t_bypass();
    t_auto();
    t_manual();
    t_freeze();
    t_shape();
    report_and_stop();
  end
  // Watchdog against a hang
  initial
  begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    report_and_stop();
  end
endmodule : speed_reference_conditioner_bench
`default_nettype wire
